// file: src/cfg_access_pkg.sv
package cfg_access_pkg;
	// access sizes
	typedef enum logic [1:0] {
		size_byte,
		size_word,
		size_dword,
		size_oversize
	} access_size_t;

	// request source
	typedef enum logic [1:0] {
		src_local_core,
		src_remote_socket,
		src_mmio
	} request_source_t;

	// completion status
	typedef enum logic [1:0] {
		cpl_normal,
		cpl_master_abort,
		cpl_dropped
	} completion_t;

	localparam logic [7:0] uncore_bus_number_config_off = 8'hcc;
	localparam logic [7:0] first_uncore_bus_rst = 8'h00;
	localparam logic [7:0] second_uncore_bus_rst = 8'h01;
	localparam int first_uncore_bus_lsb = 0;
	localparam int second_uncore_bus_lsb = 8;
	localparam logic second_uncore_bus_valid_rst = 1'b0;
	localparam int second_uncore_bus_valid_bit = 31;
	localparam logic [4:0] hub_device = 5'h00;
	localparam logic [2:0] hub_function = 3'h2;
	localparam logic [4:0] scratch_device = 5'h00;
	localparam logic [2:0] scratch_function = 3'h3;
	localparam logic [7:0] scratch_sticky_off = 8'h40;
	localparam logic [7:0] scratch_plain_off = 8'h44;
	localparam logic [7:0] id_off = 8'h00;
	localparam logic [31:0] scratch_rst = 32'h0000_0000;
	localparam logic [31:0] all_ones = 32'hffff_ffff;
	localparam logic [31:0] all_zeros = 32'h0000_0000;
	// identity codes: arbitrary values, they name no real maker or part
	localparam logic [15:0] vendor_code = 16'h1234;
	localparam logic [15:0] device_code = 16'h5678;
	localparam int mem_depth = 4;
	localparam int mem_addr_w = 2;
	localparam logic [7:0] bus_range_mask_1 = 8'hff;
endpackage

// file: src/cfg_store_if.sv
`timescale 1ns/1ps
interface cfg_store_if;
	logic wr_en;
	logic [1:0] addr;
	logic [3:0] byte_en;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport master (
		output wr_en,
		output addr,
		output byte_en,
		output wdata,
		input rdata
	);
	modport store (
		input wr_en,
		input addr,
		input byte_en,
		input wdata,
		output rdata
	);
endinterface

// file: src/cfg_store_mem.sv
`timescale 1ns/1ps
// **********************************
// byte-lane scratch store
// **********************************
module cfg_store_mem (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic pwr_good_n_in,
	// access
	cfg_store_if.store port
);
	import cfg_access_pkg::*;

	logic [31:0] mem_r [mem_depth];
	logic [31:0] mem_nxt [mem_depth];
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	always_comb begin
		for (int i = 0; i < mem_depth; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (port.wr_en) begin
			for (int b = 0; b < 4; b++) begin
				if (port.byte_en[b]) begin
					mem_nxt[port.addr][b*8 +: 8] = port.wdata[b*8 +: 8];
				end
			end
		end
		rdata_nxt = mem_r[port.addr];
	end

	// sticky: only the power-good reset clears it
	always_ff @(posedge sys_clk_in or negedge pwr_good_n_in) begin
		if (!pwr_good_n_in) begin
			for (int i = 0; i < mem_depth; i++) begin
				mem_r[i] <= scratch_rst;
			end
			rdata_r <= scratch_rst;
		end else begin
			mem_r <= mem_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign port.rdata = rdata_r;
endmodule

// file: src/config_space_access_decoder.sv
`timescale 1ns/1ps
// Function
// - accept byte, word or doubleword accesses
// - multi-byte fields little-endian by address
// - unimplemented function read returns all ones
// - master abort raises no error report
// - unimplemented function write discarded, normal completion
// - unimplemented register bits read zero; bits 16-30 at 0xcc are stored and read back as written
// - unimplemented register write ignored, normal completion
// - mmio accepts 1, 2, 4, 8 bytes; an oversize request here is answered as zero with no state change
// - hidden child config accesses dropped when enabled
// - children reachable through config and memory windows
// - bus numbers at 0xcc reset 0, 1
// - unique bus:device:function, type 0 header
// - socket bus from range and socket number
// - all accesses via central message channel hub
// - remote accesses arrive as noncoherent transfers
// - hard reset restores non-sticky bits
// - sticky bits cleared only by power good
module config_space_access_decoder (
	// clock and resets
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic pwr_good_n_in,
	// message channel request
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire cfg_access_pkg::request_source_t req_source_in,
	input wire cfg_access_pkg::access_size_t req_size_in,
	input wire logic [7:0] req_bus_in,
	input wire logic [4:0] req_device_in,
	input wire logic [2:0] req_function_in,
	input wire logic [11:0] req_offset_in,
	input wire logic [31:0] req_wdata_in,
	// storage-management function
	input wire logic child_hide_enable_in,
	input wire logic [7:0] child_bus_low_in,
	input wire logic [7:0] child_bus_high_in,
	// socket bus derivation
	input wire logic [2:0] socket_id_in,
	input wire logic [1:0] max_bus_range_in,
	// completion
	output logic cpl_valid_out,
	output cfg_access_pkg::completion_t cpl_status_out,
	output logic [31:0] cpl_rdata_out,
	output logic [7:0] socket_bus_number_out,
	output logic [7:0] first_uncore_bus_out,
	output logic [7:0] second_uncore_bus_out
);
	import cfg_access_pkg::*;

	// **********************************
	// decode helpers
	// **********************************
	function automatic logic [3:0] lane_mask(input access_size_t sz, input logic [1:0] a);
		logic [3:0] m;
		m = 4'h0;
		case (sz)
			size_byte: m = 4'h1 << a;
			size_word: m = a[1] ? 4'hc : 4'h3;
			size_dword: m = 4'hf;
			default: m = 4'h0;
		endcase
		return m;
	endfunction

	function automatic logic [31:0] lane_bits(input logic [3:0] m);
		return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction

	// **********************************
	// state
	// **********************************
	logic [31:0] bus_cfg_r;
	logic [31:0] bus_cfg_nxt;
	logic [31:0] plain_r;
	logic [31:0] plain_nxt;
	logic cpl_valid_r;
	logic cpl_valid_nxt;
	completion_t cpl_status_r;
	completion_t cpl_status_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic sel_store_r;
	logic sel_store_nxt;
	logic [3:0] rd_mask_r;
	logic [3:0] rd_mask_nxt;
	logic [7:0] socket_bus_r;
	logic [7:0] socket_bus_nxt;

	cfg_store_if store_bus ();

	cfg_store_mem u_store (
		.sys_clk_in(sys_clk_in),
		.pwr_good_n_in(pwr_good_n_in),
		.port(store_bus.store)
	);

	logic [1:0] lane_addr;
	logic [3:0] mask;
	logic [31:0] wmask;
	logic [31:0] shifted_wdata;
	logic hit_hub;
	logic hit_scratch;
	logic hidden;
	logic size_ok;
	logic [7:0] uncore_bus1;

	always_comb begin
		lane_addr = req_offset_in[1:0];
		mask = lane_mask(req_size_in, lane_addr);
		wmask = lane_bits(mask);
		// data arrives in the low lanes and is moved to its byte address
		shifted_wdata = req_wdata_in << {lane_addr, 3'b000};
		// 8-byte mmio transfers are split into dwords before they reach this port
		size_ok = (req_size_in != size_oversize);
		uncore_bus1 = bus_cfg_r[second_uncore_bus_lsb +: 8];
		// uncore functions live on the second uncore bus
		hit_hub = (req_bus_in == uncore_bus1) && (req_device_in == hub_device)
			&& (req_function_in == hub_function);
		hit_scratch = (req_bus_in == uncore_bus1) && (req_device_in == scratch_device)
			&& (req_function_in == scratch_function);
		// plain config cycles to the hidden children are dropped; windows stay outside this block
		hidden = child_hide_enable_in && (req_bus_in >= child_bus_low_in)
			&& (req_bus_in <= child_bus_high_in);
	end

	// **********************************
	// request handling
	// **********************************
	always_comb begin
		bus_cfg_nxt = bus_cfg_r;
		plain_nxt = plain_r;
		cpl_valid_nxt = 1'b0;
		cpl_status_nxt = cpl_status_r;
		rdata_nxt = rdata_r;
		sel_store_nxt = 1'b0;
		rd_mask_nxt = rd_mask_r;
		store_bus.wr_en = 1'b0;
		store_bus.addr = req_offset_in[3:2];
		store_bus.byte_en = mask;
		store_bus.wdata = shifted_wdata;
		// both local and remote sources are served alike through this hub
		if (req_valid_in) begin
			cpl_valid_nxt = 1'b1;
			cpl_status_nxt = cpl_normal;
			rd_mask_nxt = mask;
			rdata_nxt = all_zeros;
			if (hidden) begin
				cpl_status_nxt = cpl_dropped;
			end else if (!size_ok) begin
				// oversized: undefined by contract, answered as zero and no state change
				cpl_status_nxt = cpl_normal;
			end else if (hit_hub) begin
				case (req_offset_in[11:2])
					{4'h0, id_off[7:2]}: rdata_nxt = {device_code, vendor_code}; // arbitrary identity values
					{4'h0, uncore_bus_number_config_off[7:2]}: begin
						rdata_nxt = bus_cfg_r;
						if (req_write_in) begin
							bus_cfg_nxt = (bus_cfg_r & ~wmask) | (shifted_wdata & wmask);
						end
					end
					default: rdata_nxt = all_zeros;
				endcase
			end else if (hit_scratch) begin
				// the plain word is carved out of the sticky window so both stay reachable
				if (req_offset_in[11:2] == {4'h0, scratch_plain_off[7:2]}) begin
					rdata_nxt = plain_r;
					if (req_write_in) begin
						plain_nxt = (plain_r & ~wmask) | (shifted_wdata & wmask);
					end
				end else if (req_offset_in[11:4] == {4'h0, scratch_sticky_off[7:4]}) begin
					sel_store_nxt = !req_write_in;
					store_bus.wr_en = req_write_in;
				end else begin
					rdata_nxt = all_zeros;
				end
			end else begin
				// no error report is raised; all ones is the only sign
				rdata_nxt = req_write_in ? all_zeros : all_ones;
				rd_mask_nxt = 4'hf;
			end
		end
		case (max_bus_range_in)
			2'b00: socket_bus_nxt = {socket_id_in, 5'h00};
			2'b01: socket_bus_nxt = {1'b0, socket_id_in[1:0], 5'h00};
			2'b10: socket_bus_nxt = {2'b00, socket_id_in[0], 5'h00};
			default: socket_bus_nxt = 8'h00 & bus_range_mask_1;
		endcase
	end

	// hard reset restores every non-sticky register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_cfg_r <= {second_uncore_bus_valid_rst, 15'h0000, second_uncore_bus_rst, first_uncore_bus_rst};
			plain_r <= scratch_rst;
			cpl_valid_r <= 1'b0;
			cpl_status_r <= cpl_normal;
			rdata_r <= all_zeros;
			sel_store_r <= 1'b0;
			rd_mask_r <= 4'h0;
			socket_bus_r <= 8'h00;
		end else begin
			bus_cfg_r <= bus_cfg_nxt;
			plain_r <= plain_nxt;
			cpl_valid_r <= cpl_valid_nxt;
			cpl_status_r <= cpl_status_nxt;
			rdata_r <= rdata_nxt;
			sel_store_r <= sel_store_nxt;
			rd_mask_r <= rd_mask_nxt;
			socket_bus_r <= socket_bus_nxt;
		end
	end

	// **********************************
	// outputs
	// **********************************
	logic [31:0] raw_rdata;
	assign raw_rdata = sel_store_r ? store_bus.rdata : rdata_r;
	// addressed lanes return data, other lanes zero; absent-function reads return all four lanes
	assign cpl_rdata_out = raw_rdata & lane_bits(rd_mask_r);
	assign cpl_valid_out = cpl_valid_r;
	assign cpl_status_out = cpl_status_r;
	assign socket_bus_number_out = socket_bus_r;
	assign first_uncore_bus_out = bus_cfg_r[first_uncore_bus_lsb +: 8];
	assign second_uncore_bus_out = bus_cfg_r[second_uncore_bus_lsb +: 8];
endmodule

// file: sim/config_space_access_decoder_chk.sv
`timescale 1ns/1ps
// ****
// completion checks
// ****
module config_space_access_decoder_chk (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// request
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire cfg_access_pkg::access_size_t req_size_in,
	input wire logic [7:0] req_bus_in,
	input wire logic [4:0] req_device_in,
	input wire logic [2:0] req_function_in,
	input wire logic [11:0] req_offset_in,
	input wire logic child_hide_enable_in,
	input wire logic [7:0] child_bus_low_in,
	input wire logic [7:0] child_bus_high_in,
	input wire logic [2:0] socket_id_in,
	input wire logic [1:0] max_bus_range_in,
	// completion
	input wire logic cpl_valid_out,
	input wire cfg_access_pkg::completion_t cpl_status_out,
	input wire logic [31:0] cpl_rdata_out,
	input wire logic [7:0] socket_bus_number_out,
	input wire logic [7:0] first_uncore_bus_out,
	input wire logic [7:0] second_uncore_bus_out
);
	import cfg_access_pkg::*;
	logic hid;
	logic imp;
	logic ok;
	assign hid = child_hide_enable_in && req_bus_in >= child_bus_low_in && req_bus_in <= child_bus_high_in;
	assign imp = req_bus_in == second_uncore_bus_out && req_device_in == hub_device
		&& req_function_in inside {hub_function, scratch_function};
	assign ok = req_valid_in && !hid && req_size_in != size_oversize;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_cpl; req_valid_in |=> cpl_valid_out; endproperty
	a_cpl: assert property (p_cpl) else $error("completion missing");
	property p_abort; ok && !imp && !req_write_in |=> cpl_rdata_out == all_ones && cpl_status_out == cpl_normal; endproperty
	a_abort: assert property (p_abort) else $error("absent target read wrong");
	property p_wr; ok && req_write_in |=> cpl_status_out == cpl_normal; endproperty
	a_wr: assert property (p_wr) else $error("write status wrong");
	property p_drop; req_valid_in && hid |=> cpl_status_out == cpl_dropped && cpl_rdata_out == all_zeros; endproperty
	a_drop: assert property (p_drop) else $error("hidden access not dropped");
	// a byte access to an implemented function may only light its own lane
	property p_lane; ok && imp && req_size_in == size_byte
		|=> (cpl_rdata_out & ~(32'h0000_00ff << {$past(req_offset_in[1:0]), 3'h0})) == all_zeros; endproperty
	a_lane: assert property (p_lane) else $error("byte lane leak");
	property p_keep; ok && imp && req_write_in && req_size_in == size_byte && req_offset_in == 12'h0cc
		|=> $stable(second_uncore_bus_out); endproperty
	a_keep: assert property (p_keep) else $error("unaddressed lane changed");
	property p_rst; $rose(rst_n_in)
		|-> first_uncore_bus_out == first_uncore_bus_rst && second_uncore_bus_out == second_uncore_bus_rst; endproperty
	a_rst: assert property (p_rst) else $error("bus number reset wrong");
	property p_sock; max_bus_range_in == 2'h0 |=> socket_bus_number_out == {$past(socket_id_in), 5'h00}; endproperty
	a_sock: assert property (p_sock) else $error("socket bus wrong");
endmodule
bind config_space_access_decoder config_space_access_decoder_chk chk (.*);

// file: sim/cfg_core_model.sv
`timescale 1ns/1ps
// ****
// requesting core
// ****
module cfg_core_model (
	// clock
	input wire logic sys_clk_in,
	// request
	output logic v_out,
	output logic w_out,
	output cfg_access_pkg::access_size_t z_out,
	output logic [7:0] b_out,
	output logic [2:0] f_out,
	output logic [11:0] o_out,
	output logic [31:0] wd_out,
	// completion
	input wire logic cv_in,
	input wire cfg_access_pkg::completion_t cs_in,
	input wire logic [31:0] cr_in
);
	import cfg_access_pkg::*;
	initial begin
		v_out = 1'b0;
		w_out = 1'b0;
		z_out = size_dword;
		{b_out, f_out, o_out, wd_out} = '0;
	end
	// only byte, word or dword; oversize and model registers only when a test asks
	task req(input logic w, input access_size_t z, input logic [7:0] b, input logic [2:0] f,
		input logic [11:0] o, input logic [31:0] wd, output logic [31:0] rd, output completion_t st);
		@(posedge sys_clk_in);
		#1;
		v_out = 1'b1;
		w_out = w;
		z_out = z;
		b_out = b;
		f_out = f;
		o_out = o;
		wd_out = wd;
		@(posedge sys_clk_in);
		#1;
		rd = (cv_in === 1'b1) ? cr_in : 'x;
		// a missing completion reports a status the block never gives
		st = (cv_in === 1'b1) ? cs_in : cpl_master_abort;
		v_out = 1'b0;
		// released lines except the size flip so a stale value never passes
		w_out = ~w;
		b_out = ~b;
		f_out = ~f;
		o_out = ~o;
		wd_out = ~wd;
	endtask
endmodule

// file: sim/config_space_access_decoder_tb_top.sv
`timescale 1ns/1ps
module config_space_access_decoder_tb_top;
	import cfg_access_pkg::*;
	logic sys_clk_in, rst_n_in, pwr_good_n_in, req_valid_in, req_write_in, child_hide_enable_in, cpl_valid_out;
	request_source_t req_source_in;
	access_size_t req_size_in;
	completion_t cpl_status_out;
	logic [7:0] req_bus_in, child_bus_low_in, child_bus_high_in;
	logic [7:0] socket_bus_number_out, first_uncore_bus_out, second_uncore_bus_out;
	logic [4:0] req_device_in;
	logic [2:0] req_function_in, socket_id_in;
	logic [11:0] req_offset_in;
	logic [31:0] req_wdata_in, cpl_rdata_out;
	logic [1:0] max_bus_range_in;
	logic [7:0] sb [4] = '{8'ha0, 8'h20, 8'h20, 8'h00};
	int fail_count, checks;
	assign req_source_in = src_remote_socket;
	assign req_device_in = hub_device;
	config_space_access_decoder dut (.*);
	cfg_core_model m (.sys_clk_in, .v_out(req_valid_in), .w_out(req_write_in), .z_out(req_size_in),
		.b_out(req_bus_in), .f_out(req_function_in), .o_out(req_offset_in), .wd_out(req_wdata_in),
		.cv_in(cpl_valid_out), .cs_in(cpl_status_out), .cr_in(cpl_rdata_out));
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	task final_report();
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// write data is not compared: its completion carries no defined value
	task t(input logic w, input access_size_t z, input logic [7:0] b, input logic [2:0] f,
		input logic [11:0] o, input logic [31:0] wd, input logic [31:0] er, input completion_t es);
		logic [31:0] rd;
		completion_t st;
		m.req(w, z, b, f, o, wd, rd, st);
		if (!w)
			chk("rdata", rd, er);
		chk("status", st, es);
	endtask
	task rs();
		rst_n_in = 1'b0;
		repeat (8) @(posedge sys_clk_in);
		#1;
		rst_n_in = 1'b1;
		pwr_good_n_in = 1'b1;
	endtask
	initial begin
		#20000;
		fail_count++;
		final_report();
	end
	initial begin
		fail_count = 0;
		checks = 0;
		pwr_good_n_in = 1'b0;
		child_hide_enable_in = 1'b0;
		child_bus_low_in = 8'h10;
		child_bus_high_in = 8'h20;
		socket_id_in = 3'h5;
		max_bus_range_in = 2'h0;
		rs();
		t(0, size_dword, 8'h01, 3'h2, 12'h0cc, 32'h0, 32'h0000_0100, cpl_normal);
		t(0, size_word, 8'h01, 3'h2, 12'h002, 32'h0, {device_code, 16'h0000}, cpl_normal);
		t(1, size_byte, 8'h01, 3'h2, 12'h0cc, 32'h5, 32'h0, cpl_normal);
		chk("first_bus", first_uncore_bus_out, 32'h5);
		t(0, size_byte, 8'h01, 3'h2, 12'h0cd, 32'h0, 32'h0000_0100, cpl_normal);
		t(0, size_dword, 8'h01, 3'h7, 12'h0cc, 32'h0, 32'hffff_ffff, cpl_normal);
		t(1, size_dword, 8'h01, 3'h7, 12'h0cc, 32'h0, 32'h0, cpl_normal);
		t(1, size_dword, 8'h01, 3'h2, 12'h010, 32'hffff_ffff, 32'h0, cpl_normal);
		t(0, size_dword, 8'h01, 3'h2, 12'h010, 32'h0, 32'h0, cpl_normal);
		t(1, size_oversize, 8'h01, 3'h2, 12'h0cc, 32'h0, 32'h0, cpl_normal);
		t(0, size_oversize, 8'h01, 3'h2, 12'h0cc, 32'h0, 32'h0, cpl_normal);
		t(0, size_dword, 8'h01, 3'h2, 12'h0cc, 32'h0, 32'h0000_0105, cpl_normal);
		t(1, size_word, 8'h01, 3'h2, 12'h0ce, 32'h8001, 32'h0, cpl_normal);
		t(0, size_dword, 8'h01, 3'h2, 12'h0cc, 32'h0, 32'h8001_0105, cpl_normal);
		child_hide_enable_in = 1'b1;
		t(1, size_dword, 8'h10, 3'h2, 12'h0cc, 32'h0, 32'h0, cpl_dropped);
		t(0, size_dword, 8'h20, 3'h2, 12'h0cc, 32'h0, 32'h0, cpl_dropped);
		t(0, size_dword, 8'h21, 3'h2, 12'h0cc, 32'h0, 32'hffff_ffff, cpl_normal);
		child_hide_enable_in = 1'b0;
		t(1, size_dword, 8'h01, 3'h3, 12'h044, 32'h1122_3344, 32'h0, cpl_normal);
		t(1, size_byte, 8'h01, 3'h3, 12'h046, 32'h0000_00ee, 32'h0, cpl_normal);
		t(0, size_word, 8'h01, 3'h3, 12'h046, 32'h0, 32'h11ee_0000, cpl_normal);
		t(1, size_dword, 8'h01, 3'h3, 12'h040, 32'ha5a5_5a5a, 32'h0, cpl_normal);
		t(1, size_word, 8'h01, 3'h3, 12'h042, 32'h1234, 32'h0, cpl_normal);
		rs();
		t(0, size_dword, 8'h01, 3'h3, 12'h040, 32'h0, 32'h1234_5a5a, cpl_normal);
		t(0, size_dword, 8'h01, 3'h3, 12'h044, 32'h0, 32'h0, cpl_normal);
		t(0, size_dword, 8'h01, 3'h2, 12'h0cc, 32'h0, 32'h0000_0100, cpl_normal);
		pwr_good_n_in = 1'b0;
		repeat (2) @(posedge sys_clk_in);
		#1;
		pwr_good_n_in = 1'b1;
		t(0, size_dword, 8'h01, 3'h3, 12'h040, 32'h0, 32'h0, cpl_normal);
		for (int r = 0; r < 4; r++) begin
			max_bus_range_in = r[1:0];
			repeat (2) @(posedge sys_clk_in);
			#1;
			chk("socket_bus", socket_bus_number_out, sb[r]);
		end
		final_report();
	end
endmodule
